/* File: rtl/eprom_pkg.sv */
// constants, types and mode encodings for the eprom programming and protection port
// assumes a single 125 MHz clock domain and a classic wishbone master with 32-bit data
//
// Functional notes
// (RQ1) the programmer writes each code byte with five low pulses on the program pulse input under high supply, about 100 us per byte.
// (RQ2) the device holds encryption key bytes that read as all ones until programmed.
// (RQ3) verified code comes out xnor-combined with one key byte chosen in a fixed sequence.
// (RQ4) a key byte of ffh leaves the verified code byte unchanged.
// (RQ5) the programmer should fill unused code with varied values other than ffh so that keys are not revealed.
// (RQ6) encryption takes effect only while the first lock bit is set.
// (RQ7) erasing returns code, key array and all lock bits to the unprogrammed state.
// (RQ8) program-code mode is reset high, store strobe low, p2 six/seven low/high, p3 three/six/seven high, under high supply with strobe pulses.
// (RQ9) program-key mode is reset high, store strobe low, p2 six/seven low/high, p3 three high, six low, seven high.
// (RQ10) verify mode is reset high, store strobe low, strobe high, normal supply, p2 six/seven low, p3 three low, six/seven high.
// (RQ11) first lock bit mode is p2 six/seven high and p3 three/six/seven high; once set it blocks table reads and further programming.
// (RQ12) second lock bit mode is p2 six/seven high, p3 three high, six/seven low; once set it also refuses verification.
// (RQ13) third lock bit mode is p2 six high, seven low, p3 three/six/seven high/high/low; once set it also blocks external execution.
// (RQ14) writing one to the strobe inhibit bit stops the device driving address-latch strobe pulses.
// (RQ15) the key byte index is the low code address bits modulo the key array length.
// (RQ16) strobe pulses are ignored in undefined mode combinations and in program modes blocked by a lock bit.
package eprom_pkg;

  // register map, byte addresses
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control register fields
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;

  // status register fields
  localparam int STATUS_LOCK_LSB = 0;
  localparam int STATUS_MODE_LSB = 4;
  localparam int STATUS_INHIBIT_BIT = 8;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [2:0] LOCKS_CLEAR = 3'h0;

  // lock bit positions
  localparam int LOCK_FIRST = 0;
  localparam int LOCK_SECOND = 1;
  localparam int LOCK_THIRD = 2;

  // address-latch strobe period in normal running, one high cycle per period
  localparam logic [1:0] STROBE_LAST = 2'h3;
  localparam logic [1:0] STROBE_ZERO = 2'h0;

  // port pin patterns {p2_6, p2_7, p3_3, p3_6, p3_7}
  localparam logic [4:0] PAT_PROGRAM_PULSE_INPUT_CODE = 5'h0f;
  localparam logic [4:0] PAT_VERIFY = 5'h03;
  localparam logic [4:0] PAT_PROGRAM_PULSE_INPUT_KEY = 5'h0d;
  localparam logic [4:0] PAT_LOCK1 = 5'h1f;
  localparam logic [4:0] PAT_SECOND_LOCK_BIT = 5'h1c;
  localparam logic [4:0] PAT_THIRD_LOCK_BIT = 5'h16;

  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_PROGRAM_PULSE_INPUT_CODE = 3'b001,
    MODE_VERIFY = 3'b010,
    MODE_PROGRAM_PULSE_INPUT_KEY = 3'b011,
    MODE_LOCK1 = 3'b100,
    MODE_SECOND_LOCK_BIT = 3'b101,
    MODE_THIRD_LOCK_BIT = 3'b110
  } program_pulse_input_mode_e;

  // static mode pins driven by the programmer
  typedef struct packed {
    logic reset_pin;
    logic program_store_strobe;
    logic high_supply;
    logic port_two_bit_six;
    logic port_two_bit_seven;
    logic port_three_bit_three;
    logic port_three_bit_six;
    logic port_three_bit_seven;
  } program_pulse_input_pins_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

endpackage

/* File: rtl/eprom_program_protect_port.sv */
// eprom programming, verification and lock logic with a wishbone control slave
// assumes pins are synchronous to clk_i and the programmer holds mode pins static
`timescale 1ns/1ps
`default_nettype none

module eprom_program_protect_port #(
  parameter int ADDR_W = 13,
  parameter int CODE_DEPTH = 8192,
  parameter int KEY_DEPTH = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire eprom_pkg::program_pulse_input_pins_s pins_i,
  input wire logic [ADDR_W-1:0] program_pulse_input_addr_i,
  input wire logic [7:0] program_pulse_input_data_i,
  output logic [7:0] program_pulse_input_data_o,
  output logic program_pulse_input_data_oe_n_o,
  input wire logic ale_i,
  output logic ale_o,
  output logic ale_oe_n_o,
  input wire eprom_pkg::wb_req_s wb_i,
  output eprom_pkg::wb_rsp_s wb_o,
  output logic table_read_block_o,
  output logic ext_exec_block_o
);
  import eprom_pkg::*;

  localparam int KEY_AW = $clog2(KEY_DEPTH);

  // elaboration checks: the cell array must cover the address space exactly
  if (CODE_DEPTH != (1 << ADDR_W))
  begin : g_bad_code_depth
    $error("CODE_DEPTH must equal 2**ADDR_W");
  end
  if (KEY_DEPTH < 2 || KEY_DEPTH != (1 << KEY_AW) || KEY_DEPTH > CODE_DEPTH)
  begin : g_bad_key_depth
    $error("KEY_DEPTH must be a power of two between 2 and CODE_DEPTH");
  end

  logic [7:0] code_mem [CODE_DEPTH];
  logic [7:0] key_mem [KEY_DEPTH];
  logic [2:0] lock_reg;
  logic inhibit_reg;
  logic erase_reg;
  logic ale_prev_reg;
  logic [1:0] strobe_cnt_reg;
  program_pulse_input_mode_e mode;
  logic [4:0] port_pat;
  logic program_pulse_input_fall;
  logic code_wr;
  logic key_wr;
  logic [2:0] lock_set;
  logic [7:0] code_rd;
  logic [7:0] key_rd;
  logic [7:0] verify_byte;
  logic wb_hit;
  logic wb_wr;
  logic [31:0] status_word;

  assign port_pat = {pins_i.port_two_bit_six, pins_i.port_two_bit_seven,
                     pins_i.port_three_bit_three, pins_i.port_three_bit_six,
                     pins_i.port_three_bit_seven};

  // mode decode; anything not listed stays idle so its pulses fall on the floor
  always_comb
  begin
    mode = MODE_IDLE;
    if (pins_i.reset_pin && !pins_i.program_store_strobe)
    begin
      if (pins_i.high_supply)
      begin
        // (RQ8) program code select
        if (port_pat == PAT_PROGRAM_PULSE_INPUT_CODE)
          mode = MODE_PROGRAM_PULSE_INPUT_CODE;
        // (RQ9) program key select
        else if (port_pat == PAT_PROGRAM_PULSE_INPUT_KEY)
          mode = MODE_PROGRAM_PULSE_INPUT_KEY;
        // (RQ11) first lock select
        else if (port_pat == PAT_LOCK1)
          mode = MODE_LOCK1;
        // (RQ12) second lock select
        else if (port_pat == PAT_SECOND_LOCK_BIT)
          mode = MODE_SECOND_LOCK_BIT;
        // (RQ13) third lock select
        else if (port_pat == PAT_THIRD_LOCK_BIT)
          mode = MODE_THIRD_LOCK_BIT;
      end
      // (RQ10) verify select, strobe held high
      else if (port_pat == PAT_VERIFY && ale_i)
        mode = MODE_VERIFY;
    end
  end

  // each falling edge of the pulse input is one programming pulse
  assign program_pulse_input_fall = ce_i && ale_prev_reg && !ale_i;

  // (RQ16) blocked or undefined pulses ignored
  // (RQ12) every lock carries the first lock's programming block
  assign code_wr = program_pulse_input_fall && mode == MODE_PROGRAM_PULSE_INPUT_CODE && lock_reg == LOCKS_CLEAR;
  assign key_wr = program_pulse_input_fall && mode == MODE_PROGRAM_PULSE_INPUT_KEY && lock_reg == LOCKS_CLEAR;
  assign lock_set[LOCK_FIRST] = program_pulse_input_fall && mode == MODE_LOCK1;
  assign lock_set[LOCK_SECOND] = program_pulse_input_fall && mode == MODE_SECOND_LOCK_BIT;
  assign lock_set[LOCK_THIRD] = program_pulse_input_fall && mode == MODE_THIRD_LOCK_BIT;

  assign code_rd = code_mem[program_pulse_input_addr_i];
  // (RQ15) key index from low address bits
  assign key_rd = key_mem[program_pulse_input_addr_i[KEY_AW-1:0]];
  // (RQ3) xnor with key byte; (RQ6) only while locked
  assign verify_byte = lock_reg[LOCK_FIRST] ? ~(code_rd ^ key_rd) : code_rd;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ale_prev_reg <= 1'b1;
    else if (ce_i)
      ale_prev_reg <= ale_i;
  end

  // cells only lose ones when programmed, so the five repeated pulses per byte
  // land the same value again; an erase in the same cycle is overridden by the write
  genvar gi;
  generate
    for (gi = 0; gi < CODE_DEPTH; gi++)
    begin : g_code
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          code_mem[gi] <= ERASED_BYTE;
        // (RQ1) each pulse programs; (RQ7) erase
        else if (ce_i && (erase_reg || (code_wr && program_pulse_input_addr_i == gi)))
          code_mem[gi] <= (erase_reg ? ERASED_BYTE : code_mem[gi])
                          & ((code_wr && program_pulse_input_addr_i == gi) ? program_pulse_input_data_i : ERASED_BYTE);
      end
    end
    for (gi = 0; gi < KEY_DEPTH; gi++)
    begin : g_key
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        // (RQ2) key cells start erased
        if (rst_i)
          key_mem[gi] <= ERASED_BYTE;
        // (RQ7) erase also clears keys
        else if (ce_i && (erase_reg || (key_wr && program_pulse_input_addr_i[KEY_AW-1:0] == gi)))
          key_mem[gi] <= (erase_reg ? ERASED_BYTE : key_mem[gi])
                         & ((key_wr && program_pulse_input_addr_i[KEY_AW-1:0] == gi) ? program_pulse_input_data_i
                                                                       : ERASED_BYTE);
      end
    end
  endgenerate

  // (RQ11) lock bits accumulate; (RQ7) erase clears, a pulse in the same cycle wins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      lock_reg <= LOCKS_CLEAR;
    else if (ce_i)
      lock_reg <= (erase_reg ? LOCKS_CLEAR : lock_reg) | lock_set;
  end

  // (RQ11) table reads blocked by any lock; (RQ13) external execution by the third
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      table_read_block_o <= 1'b0;
      ext_exec_block_o <= 1'b0;
    end
    else if (ce_i)
    begin
      table_read_block_o <= |lock_reg;
      ext_exec_block_o <= lock_reg[LOCK_THIRD];
    end
  end

  // verify data bus; released outside verify so the programmer can drive data
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      program_pulse_input_data_o <= ERASED_BYTE;
      program_pulse_input_data_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      program_pulse_input_data_oe_n_o <= (mode != MODE_VERIFY);
      // (RQ12) verify refused, reads as ones
      if (lock_reg[LOCK_SECOND] || lock_reg[LOCK_THIRD])
        program_pulse_input_data_o <= ERASED_BYTE;
      // (RQ4) ff key passes code
      else
        program_pulse_input_data_o <= verify_byte;
    end
  end

  // normal strobe generation; the pin turns to an input whenever reset is high
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strobe_cnt_reg <= STROBE_ZERO;
      ale_o <= 1'b0;
      ale_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      strobe_cnt_reg <= (strobe_cnt_reg == STROBE_LAST) ? STROBE_ZERO : strobe_cnt_reg + 2'h1;
      ale_oe_n_o <= pins_i.reset_pin;
      // (RQ14) inhibit holds the strobe low
      ale_o <= !inhibit_reg && !pins_i.reset_pin && strobe_cnt_reg == STROBE_LAST;
    end
  end

  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  assign wb_hit = wb_i.cyc && wb_i.stb && !wb_o.ack;
  assign wb_wr = ce_i && wb_hit && wb_i.we && wb_i.sel[0]
                 && wb_i.adr[7:2] == CTRL_OFFSET[7:2];

  always_comb
  begin
    status_word = WORD_ZERO;
    status_word[STATUS_LOCK_LSB +: 3] = lock_reg;
    status_word[STATUS_MODE_LSB +: 3] = mode;
    status_word[STATUS_INHIBIT_BIT] = inhibit_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      inhibit_reg <= 1'b0;
    else if (wb_wr)
      inhibit_reg <= wb_i.dat[CTRL_INHIBIT_BIT];
  end

  // erase is a one-cycle command; reads back as zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      erase_reg <= 1'b0;
    else if (ce_i)
      erase_reg <= wb_wr && wb_i.dat[CTRL_ERASE_BIT];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wb_o <= '0;
    else if (ce_i)
    begin
      wb_o.ack <= wb_hit;
      wb_o.dat <= WORD_ZERO;
      if (wb_hit && !wb_i.we)
      begin
        if (wb_i.adr[7:2] == CTRL_OFFSET[7:2])
          wb_o.dat[CTRL_INHIBIT_BIT] <= inhibit_reg;
        else if (wb_i.adr[7:2] == STATUS_OFFSET[7:2])
          wb_o.dat <= status_word;
      end
    end
  end

  property p_xnor_verify;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MODE_VERIFY && lock_reg == 3'h1
    |=> program_pulse_input_data_o == ~($past(code_rd) ^ $past(key_rd)) && !program_pulse_input_data_oe_n_o;
  endproperty
  a_xnor_verify: assert property (p_xnor_verify) else $error("verify not code xnor key"); // RQ3

  property p_ff_key_plain;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MODE_VERIFY && lock_reg[2:1] == 2'h0 && key_rd == 8'hff
    |=> program_pulse_input_data_o == $past(code_rd);
  endproperty
  a_ff_key_plain: assert property (p_ff_key_plain) else $error("ff key altered code"); // RQ4

  property p_unlocked_plain;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && mode == MODE_VERIFY && lock_reg == 3'h0 |=> program_pulse_input_data_o == $past(code_rd);
  endproperty
  a_unlocked_plain: assert property (p_unlocked_plain) else $error("encrypted without lock"); // RQ6

  property p_erase_all;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && erase_reg && !program_pulse_input_fall |=> lock_reg == 3'h0 && key_mem[0] == 8'hff
                                         && code_mem[0] == 8'hff;
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("erase left state programmed"); // RQ7

  property p_code_write;
    @(posedge clk_i) disable iff (rst_i)
    code_wr && !erase_reg
    |=> code_mem[$past(program_pulse_input_addr_i)] == ($past(code_rd) & $past(program_pulse_input_data_i));
  endproperty
  a_code_write: assert property (p_code_write) else $error("code pulse not programmed"); // RQ8

  property p_lock_blocks_program_pulse_input;
    @(posedge clk_i) disable iff (rst_i)
    program_pulse_input_fall && mode == MODE_PROGRAM_PULSE_INPUT_CODE && lock_reg != LOCKS_CLEAR && !erase_reg
    |=> code_mem[$past(program_pulse_input_addr_i)] == $past(code_rd);
  endproperty
  a_lock_blocks_program_pulse_input: assert property (p_lock_blocks_program_pulse_input) else $error("locked code changed"); // RQ11

  property p_verify_refused;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && lock_reg[LOCK_SECOND] |=> program_pulse_input_data_o == ERASED_BYTE;
  endproperty
  a_verify_refused: assert property (p_verify_refused) else $error("verify not refused"); // RQ12

  property p_ext_block;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && lock_reg[2] |=> ext_exec_block_o && table_read_block_o;
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("third lock not applied"); // RQ13

  property p_inhibit_quiet;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && inhibit_reg |=> !ale_o;
  endproperty
  a_inhibit_quiet: assert property (p_inhibit_quiet) else $error("strobe pulsed while inhibited"); // RQ14

  property p_undefined_ignored;
    @(posedge clk_i) disable iff (rst_i)
    program_pulse_input_fall && mode == MODE_IDLE && !erase_reg |=> $stable(lock_reg);
  endproperty
  a_undefined_ignored: assert property (p_undefined_ignored) else $error("idle pulse acted"); // RQ16

endmodule

`default_nettype wire

/* File: tb/eprom_programmer_model.sv */
// programmer model: drives mode pins, address, data and program pulses
// assumes the device samples every one of these on the rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer_model #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  output var eprom_pkg::program_pulse_input_pins_s pins_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [7:0] data_o,
  output logic ale_o
);
  import eprom_pkg::*;

  initial
  begin
    pins_o = '0;
    addr_o = '0;
    data_o = 8'h00;
    ale_o = 1'b1;
  end

  task automatic set_mode(input logic [4:0] pat, input logic sup);
    @(posedge clk_i);
    pins_o <= {1'b1, 1'b0, sup, pat};
  endtask

  task automatic burn(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= d;
    repeat (5)
    begin
      @(posedge clk_i);
      ale_o <= 1'b0;
      @(posedge clk_i);
      ale_o <= 1'b1;
    end
    // hold over: the data lines no longer carry the byte
    @(posedge clk_i);
    data_o <= ~d;
  endtask

  task automatic look(input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= ~data_o;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_eprom_program_protect_port.sv */
// self-checking bench for the eprom programming and protection port
// assumes the programmer model file and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_eprom_program_protect_port;
  import eprom_pkg::*;
  logic clk_i;
  logic rst_i;
  program_pulse_input_pins_s pins;
  logic [7:0] paddr;
  logic [7:0] pdat;
  logic ale_i;
  logic [7:0] dout;
  logic oe_n;
  logic ale_w;
  logic ale_oe_n;
  wb_req_s wb_i;
  wb_rsp_s wb_o;
  logic tblk;
  logic xblk;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;

  eprom_programmer_model #(.ADDR_W(8)) m (.clk_i(clk_i), .pins_o(pins), .addr_o(paddr),
    .data_o(pdat), .ale_o(ale_i));

  eprom_program_protect_port #(.ADDR_W(8), .CODE_DEPTH(256), .KEY_DEPTH(16)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pins_i(pins), .program_pulse_input_addr_i(paddr),
    .program_pulse_input_data_i(pdat), .program_pulse_input_data_o(dout), .program_pulse_input_data_oe_n_o(oe_n), .ale_i(ale_i),
    .ale_o(ale_w), .ale_oe_n_o(ale_oe_n), .wb_i(wb_i), .wb_o(wb_o), .table_read_block_o(tblk),
    .ext_exec_block_o(xblk));

  task automatic finish_test();
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: d};
    // no local limit: only the bench watchdog ends a wait that never sees ack
    do
      @(posedge clk_i);
    while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
  endtask

  task automatic vfy(input logic [7:0] a, input logic [7:0] exp);
    m.look(a);
    repeat (2) @(posedge clk_i);
    #1;
    chk({23'h0, oe_n, dout}, {24'h0, exp});
  endtask

  task automatic t_strobe(input int exp);
    int n;
    n = 0;
    repeat (8)
    begin
      @(posedge clk_i);
      #1;
      n += int'(ale_w);
    end
    chk(32'(n), 32'(exp));
  endtask

  task automatic t_program();
    m.set_mode(PAT_PROGRAM_PULSE_INPUT_CODE, 1'b1);
    m.burn(8'h01, 8'h3c);
    chk({31'h0, ale_oe_n}, 32'h0000_0001);
    m.burn(8'h11, 8'ha5);
    m.burn(8'h02, 8'h96);
    m.set_mode(PAT_PROGRAM_PULSE_INPUT_KEY, 1'b1);
    m.burn(8'h01, 8'h5a);
    m.set_mode(5'h00, 1'b1);
    m.burn(8'h02, 8'h00);
    m.set_mode(PAT_VERIFY, 1'b0);
    vfy(8'h01, 8'h3c);
    vfy(8'h02, 8'h96);
  endtask

  task automatic t_lock1();
    m.set_mode(PAT_LOCK1, 1'b1);
    m.burn(8'h00, 8'h00);
    m.set_mode(PAT_PROGRAM_PULSE_INPUT_CODE, 1'b1);
    m.burn(8'h02, 8'h00);
    m.set_mode(PAT_PROGRAM_PULSE_INPUT_KEY, 1'b1);
    m.burn(8'h01, 8'h00);
    m.set_mode(PAT_VERIFY, 1'b0);
    vfy(8'h01, 8'h99);
    vfy(8'h11, 8'h00);
    vfy(8'h02, 8'h96);
    wb(1'b0, STATUS_OFFSET, WORD_ZERO);
    chk({27'h0, rd[2:0], tblk, xblk}, {27'h0, 3'h1, 1'b1, 1'b0});
  endtask

  task automatic t_lock23();
    m.set_mode(PAT_SECOND_LOCK_BIT, 1'b1);
    m.burn(8'h00, 8'h00);
    m.set_mode(PAT_VERIFY, 1'b0);
    vfy(8'h01, 8'hff);
    m.set_mode(PAT_THIRD_LOCK_BIT, 1'b1);
    m.burn(8'h00, 8'h00);
    wb(1'b0, STATUS_OFFSET, WORD_ZERO);
    chk({27'h0, rd[2:0], tblk, xblk}, {27'h0, 3'h7, 1'b1, 1'b1});
  endtask

  task automatic t_erase();
    wb(1'b1, CTRL_OFFSET, 32'h0000_0002);
    wb(1'b0, STATUS_OFFSET, WORD_ZERO);
    chk({27'h0, rd[2:0], tblk, xblk}, {27'h0, 3'h0, 1'b0, 1'b0});
    m.set_mode(PAT_VERIFY, 1'b0);
    vfy(8'h01, 8'hff);
    vfy(8'h11, 8'hff);
    wb(1'b0, 8'h08, WORD_ZERO);
    chk(rd, WORD_ZERO);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    // whole run needs a few hundred cycles at most
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    rst_i = 1'b1;
    wb_i = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({20'h0, ale_oe_n, tblk, xblk, oe_n, dout}, {20'h0, 1'b1, 2'b00, 1'b1, 8'hff});
    t_strobe(2);
    chk({31'h0, ale_oe_n}, WORD_ZERO);
    wb(1'b1, CTRL_OFFSET, 32'h0000_0001);
    wb(1'b0, CTRL_OFFSET, WORD_ZERO);
    chk(rd, 32'h0000_0001);
    t_strobe(0);
    wb(1'b1, CTRL_OFFSET, WORD_ZERO);
    t_strobe(2);
    m.set_mode(PAT_VERIFY, 1'b0);
    vfy(8'h05, 8'hff);
    t_program();
    t_lock1();
    t_lock23();
    t_erase();
    finish_test();
  end
endmodule
`default_nettype wire
